// >>> rtl/dag_core.sv
// Data space address generation with working registers and paging
//
// How it works
// R01: A 64 Kbyte base data space splits into X and Y, each with a generator.
// R02: General instructions address only through X, over one linear map.
// R03: Dual-operand reads use X and Y at once, split at a set boundary.
// R04: Upper-half reads may map to program memory at a 16K word boundary.
// R05: Upper-half accesses otherwise page into a 16 Mbyte extended space.
// R06: X and Y generators both wrap circular buffers in hardware.
// R07: X circular wrap works for any instruction, not only dual-operand ones.
// R08: The X generator also steps pointers in bit-reversed order.
// R09: Dual reads use pointer registers dedicated to the X and Y spaces.
// R10: Sixteen 16-bit working registers, the last one the stack pointer.
// R11: Inherent, relative, literal, direct, register and indirect modes.
// R12: Memory read, register read and memory write share one cycle.
// R13: Stack pointer accesses always stay in the base data space.
// R14: Extended reads take the read page, extended writes the write page.
`timescale 1ns/1ps
`default_nettype none

module dag_core
    import dag_pkg::*;
#(
    parameter logic [15:0] Y_BASE = DAG_Y_BASE
) (
    input  wire logic                 mclk,
    input  wire logic                 sys_rst,
    input  wire dag_pkg::dag_req_type req,
    input  wire dag_pkg::dag_cfg_type cfg,
    input  wire dag_pkg::dag_wb_type  wb,
    output dag_pkg::dag_acc_type      x_rd,
    output dag_pkg::dag_acc_type      y_rd,
    output dag_pkg::dag_acc_type      wr,
    output logic [15:0]               reg_rd_data,
    output logic                      reg_rd_valid,
    output logic                      space_fault,
    output logic [15:0]               stack_pointer_register
);
    import dag_pkg::*;

    // Boundary must be a word address inside the base space
    if (Y_BASE == 16'h0000 || Y_BASE[0]) begin : g_chk
        $error("dag_core: Y_BASE must be nonzero and even");
    end

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        logic [DAG_NREG-1:0][15:0] wreg;
        dag_acc_type               x_rd;
        dag_acc_type               y_rd;
        dag_acc_type               wr;
        logic [15:0]               rd_data;
        logic                      rd_valid;
        logic                      fault;
    } dag_state_type;

    dag_state_type state_r;
    dag_state_type state_nxt;

    // ****************************************
    // Generator hookup
    // ****************************************
    logic [3:0]      xs_idx;
    logic [3:0]      ys_idx;
    dag_imod_type    xs_mod;
    dag_agu_res_type xs_res;
    dag_agu_res_type ys_res;
    dag_agu_res_type xw_res;
    dag_brev_type    brev_off;

    assign brev_off = '0;

    always_comb begin
        if (req.dual) begin
            xs_idx = req.x_sel ? DAG_X_PTR1 : DAG_X_PTR0; // R09
            xs_mod = req.x_mod;
        end else begin
            xs_idx = req.src_reg; // R02
            xs_mod = req.src_mod;
        end
        ys_idx = req.y_sel ? DAG_Y_PTR1 : DAG_Y_PTR0; // R09
    end

    // X source path
    dag_agu #(
        .AW      (DAG_DW),
        .BREV_OK (1'b1)
    ) u_x_src (
        .ptr     (state_r.wreg[xs_idx]),
        .offs    (state_r.wreg[req.offs_reg]),
        .imod    (xs_mod),
        .byte_op (req.byte_op),
        .mcfg    (cfg.xmod),
        .brev    (cfg.brev),
        .res     (xs_res)
    );

    // Y source path: modulo only, no bit reversal
    dag_agu #(
        .AW      (DAG_DW),
        .BREV_OK (1'b0)
    ) u_y_src (
        .ptr     (state_r.wreg[ys_idx]),
        .offs    (state_r.wreg[req.offs_reg]),
        .imod    (req.y_mod),
        .byte_op (req.byte_op),
        .mcfg    (cfg.ymod),
        .brev    (brev_off),
        .res     (ys_res)
    );

    // X destination path, same unit type as the source
    dag_agu #(
        .AW      (DAG_DW),
        .BREV_OK (1'b1)
    ) u_x_dst (
        .ptr     (state_r.wreg[req.dst_reg]),
        .offs    (state_r.wreg[req.offs_reg]),
        .imod    (req.dst_mod),
        .byte_op (req.byte_op),
        .mcfg    (cfg.xmod),
        .brev    (cfg.brev),
        .res     (xw_res)
    );

    // ****************************************
    // Address mapping
    // ****************************************
    function automatic dag_acc_type map_addr(
        input logic [15:0] a,
        input logic        is_wr,
        input logic        is_stk,
        input dag_cfg_type c
    );
        dag_acc_type o;
        logic [DAG_PAGE_W-1:0] pg;
        o.en = 1'b1;
        pg   = is_wr ? c.extended_write_page
                     : c.extended_read_page; // R14
        if (!a[DAG_TOP_BIT] || is_stk) begin
            // Stack never paged
            o.space = DAG_S_BASE; // R13
            o.addr  = {8'h00, a}; // R01
        end else if (!is_wr && c.psv_en) begin
            // Word address in program memory, read only
            o.space = DAG_S_PROG; // R04
            o.addr  = {1'b0, c.psv_page, a[14:1]};
        end else begin
            o.space = DAG_S_EXT; // R05
            o.addr  = {pg, a[14:0]};
        end
        return o;
    endfunction

    function automatic logic uses_mem(input dag_mode_type m);
        // Inherent, relative and literal touch no data memory
        return m == DAG_M_DIRECT || m == DAG_M_REG_INDIRECT; // R11
    endfunction

    // ****************************************
    // Next state
    // ****************************************
    logic [15:0] src_ea;
    logic [15:0] dst_ea;
    logic        src_stk;
    logic        dst_stk;

    always_comb begin
        state_nxt          = state_r;
        state_nxt.x_rd     = '0;
        state_nxt.y_rd     = '0;
        state_nxt.wr       = '0;
        state_nxt.rd_valid = 1'b0;
        state_nxt.fault    = 1'b0;
        src_ea  = (req.src_mode == DAG_M_DIRECT) ? req.direct : xs_res.ea;
        dst_ea  = (req.dst_mode == DAG_M_DIRECT) ? req.direct : xw_res.ea;
        src_stk = req.src_mode == DAG_M_REG_INDIRECT
                  && req.src_reg == DAG_SP_IDX;
        dst_stk = req.dst_mode == DAG_M_REG_INDIRECT
                  && req.dst_reg == DAG_SP_IDX;
        if (req.valid && req.dual) begin
            // Two operand reads, split space
            state_nxt.x_rd = map_addr(xs_res.ea, 1'b0, 1'b0, cfg); // R03
            state_nxt.y_rd = map_addr(ys_res.ea, 1'b0, 1'b0, cfg); // R03
            state_nxt.fault = xs_res.ea >= Y_BASE
                              || ys_res.ea < Y_BASE; // R03
            state_nxt.wreg[xs_idx] = xs_res.ptr_nxt; // R06
            state_nxt.wreg[ys_idx] = ys_res.ptr_nxt; // R06
        end else if (req.valid) begin
            if (uses_mem(req.src_mode)) begin
                state_nxt.x_rd = map_addr(src_ea, 1'b0, src_stk,
                                          cfg); // R02
            end
            if (req.src_mode == DAG_M_REG_INDIRECT) begin
                state_nxt.wreg[req.src_reg] = xs_res.ptr_nxt; // R07
            end
        end
        if (req.valid) begin
            // Register read and memory write in the same cycle
            if (req.src_mode == DAG_M_REG_DIRECT) begin
                state_nxt.rd_data  = state_r.wreg[req.src_reg]; // R12
                state_nxt.rd_valid = 1'b1;
            end
            if (uses_mem(req.dst_mode)) begin
                state_nxt.wr = map_addr(dst_ea, 1'b1, dst_stk,
                                        cfg); // R12
            end
            if (req.dst_mode == DAG_M_REG_INDIRECT) begin
                state_nxt.wreg[req.dst_reg] = xw_res.ptr_nxt; // R08
            end
        end
        // Data write to a register wins over pointer update
        if (wb.en) begin
            state_nxt.wreg[wb.idx] = wb.data; // R10
        end
        // Word aligned stack
        state_nxt.wreg[DAG_SP_IDX][0] = 1'b0; // R10
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            state_r      <= '0;
            state_r.wreg <= {DAG_NREG{DAG_WREG_RST}};
            state_r.wreg[DAG_SP_IDX] <= DAG_SP_RST; // R10
        end else begin
            state_r <= state_nxt;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign x_rd                   = state_r.x_rd;
    assign y_rd                   = state_r.y_rd;
    assign wr                     = state_r.wr;
    assign reg_rd_data            = state_r.rd_data;
    assign reg_rd_valid           = state_r.rd_valid;
    assign space_fault            = state_r.fault;
    assign stack_pointer_register = state_r.wreg[DAG_SP_IDX];

endmodule

`default_nettype wire

// >>> common/dag_pkg.sv
// Shared types and constants of the data address generation block
`default_nettype none
package dag_pkg;

    // ****************************************
    // Sizes and fixed values
    // ****************************************
    localparam int          DAG_DW       = 16;
    localparam int          DAG_NREG     = 16;
    localparam int          DAG_AW       = 24;
    localparam int          DAG_PAGE_W   = 9;
    localparam int          DAG_TOP_BIT  = 15;
    localparam logic [3:0]  DAG_SP_IDX   = 4'hf;
    localparam logic [15:0] DAG_SP_RST   = 16'h1000;
    localparam logic [15:0] DAG_WREG_RST = 16'h0000;
    localparam logic [15:0] DAG_Y_BASE   = 16'h8000;
    localparam logic [3:0]  DAG_X_PTR0   = 4'h8;
    localparam logic [3:0]  DAG_X_PTR1   = 4'h9;
    localparam logic [3:0]  DAG_Y_PTR0   = 4'ha;
    localparam logic [3:0]  DAG_Y_PTR1   = 4'hb;
    localparam logic [15:0] DAG_STEP_W   = 16'h0002;
    localparam logic [15:0] DAG_STEP_B   = 16'h0001;

    // ****************************************
    // Enumerations
    // ****************************************
    typedef enum logic [2:0] {
        DAG_M_INHERENT, DAG_M_RELATIVE, DAG_M_LITERAL,
        DAG_M_DIRECT, DAG_M_REG_DIRECT, DAG_M_REG_INDIRECT
    } dag_mode_type;

    typedef enum logic [2:0] {
        DAG_I_PLAIN, DAG_I_POST_INC, DAG_I_POST_DEC,
        DAG_I_PRE_INC, DAG_I_PRE_DEC, DAG_I_OFFSET
    } dag_imod_type;

    typedef enum logic [1:0] {
        DAG_S_BASE, DAG_S_EXT, DAG_S_PROG
    } dag_space_type;

    // ****************************************
    // Carriers
    // ****************************************
    typedef struct packed {
        logic         valid;
        logic         dual;
        logic         byte_op;
        dag_mode_type src_mode;
        dag_imod_type src_mod;
        logic [3:0]   src_reg;
        dag_mode_type dst_mode;
        dag_imod_type dst_mod;
        logic [3:0]   dst_reg;
        logic [3:0]   offs_reg;
        logic [15:0]  direct;
        logic         x_sel;
        logic         y_sel;
        dag_imod_type x_mod;
        dag_imod_type y_mod;
    } dag_req_type;

    typedef struct packed {
        logic        en;
        logic [15:0] first;
        logic [15:0] last;
    } dag_modcfg_type;

    typedef struct packed {
        logic        en;
        logic [15:0] step;
    } dag_brev_type;

    typedef struct packed {
        dag_modcfg_type         xmod;
        dag_modcfg_type         ymod;
        dag_brev_type           brev;
        logic                   psv_en;
        logic [DAG_PAGE_W-1:0]  psv_page;
        logic [DAG_PAGE_W-1:0]  extended_read_page;
        logic [DAG_PAGE_W-1:0]  extended_write_page;
    } dag_cfg_type;

    typedef struct packed {
        logic        en;
        logic [3:0]  idx;
        logic [15:0] data;
    } dag_wb_type;

    typedef struct packed {
        logic              en;
        dag_space_type     space;
        logic [DAG_AW-1:0] addr;
    } dag_acc_type;

    typedef struct packed {
        logic [15:0] ea;
        logic [15:0] ptr_nxt;
    } dag_agu_res_type;

endpackage
`default_nettype wire

// >>> rtl/dag_agu.sv
// One address generation unit: modifiers, modulo and bit reversal
`timescale 1ns/1ps
`default_nettype none

module dag_agu
    import dag_pkg::*;
#(
    parameter int   AW     = 16,
    parameter logic BREV_OK = 1'b1
) (
    input  wire logic [AW-1:0]            ptr,
    input  wire logic [AW-1:0]            offs,
    input  wire dag_pkg::dag_imod_type    imod,
    input  wire logic                     byte_op,
    input  wire dag_pkg::dag_modcfg_type  mcfg,
    input  wire dag_pkg::dag_brev_type    brev,
    output      dag_pkg::dag_agu_res_type res
);
    import dag_pkg::*;

    if (AW != DAG_DW) begin : g_chk
        $error("dag_agu: only a 16-bit pointer is served");
    end

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [14:0] rev15(input logic [14:0] v);
        logic [14:0] o;
        o = '0;
        for (int i = 0; i < 15; i++) begin
            o[i] = v[14-i];
        end
        return o;
    endfunction

    logic [15:0] step;
    logic [15:0] up;
    logic [15:0] dn;
    logic [15:0] span;
    logic        in_buf;
    logic [14:0] rsum;

    // ****************************************
    // Pointer arithmetic
    // ****************************************
    always_comb begin
        step   = byte_op ? DAG_STEP_B : DAG_STEP_W;
        span   = 16'(mcfg.last - mcfg.first + 16'h0001);
        in_buf = mcfg.en && ptr >= mcfg.first && ptr <= mcfg.last;
        up     = 16'(ptr + step);
        dn     = 16'(ptr - step);
        // Wrap without software checks
        if (in_buf && up > mcfg.last) begin // R06
            up = 16'(up - span); // R07
        end
        if (in_buf && (dn < mcfg.first || ptr < step)) begin // R06
            dn = 16'(dn + span);
        end
        // Reverse carry on word address; bit 0 kept apart
        rsum = 15'(rev15(ptr[15:1]) + rev15(brev.step[15:1]));
        if (BREV_OK && brev.en && !byte_op) begin // R08
            up = {rev15(rsum), ptr[0]};
        end
        res.ea      = ptr;
        res.ptr_nxt = ptr;
        case (imod)
            DAG_I_PLAIN:    res.ea = ptr;
            DAG_I_POST_INC: res.ptr_nxt = up;
            DAG_I_POST_DEC: res.ptr_nxt = dn;
            DAG_I_PRE_INC: begin
                res.ea      = up;
                res.ptr_nxt = up;
            end
            DAG_I_PRE_DEC: begin
                res.ea      = dn;
                res.ptr_nxt = dn;
            end
            DAG_I_OFFSET:   res.ea = 16'(ptr + offs);
            default:        res.ea = ptr;
        endcase
    end

endmodule

`default_nettype wire

// >>> tb/dag_properties.sv
// Port checks on the data address generation block
`timescale 1ns/1ps
`default_nettype none

module dag_properties (
    input wire logic                 mclk,
    input wire logic                 sys_rst,
    input wire dag_pkg::dag_req_type req,
    input wire dag_pkg::dag_cfg_type cfg,
    input wire dag_pkg::dag_acc_type x_rd,
    input wire dag_pkg::dag_acc_type y_rd,
    input wire dag_pkg::dag_acc_type wr,
    input wire logic                 reg_rd_valid,
    input wire logic [15:0]          stack_pointer_register
);
    import dag_pkg::*;

    // ****************************************
    // Properties
    // ****************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    sequence s_ind;
        req.valid && !req.dual && req.src_mode == DAG_M_REG_INDIRECT;
    endsequence
    sequence s_both;
        s_ind ##0 req.dst_mode == DAG_M_REG_INDIRECT;
    endsequence

    property p_dual;
        req.valid && req.dual |=> x_rd.en && y_rd.en;
    endproperty
    property p_x_only;
        !(req.valid && req.dual) |=> !y_rd.en;
    endproperty
    property p_rmw;
        s_both |=> x_rd.en && wr.en;
    endproperty
    property p_stack;
        s_ind ##0 req.src_reg == DAG_SP_IDX
            |=> x_rd.space == DAG_S_BASE && x_rd.addr[23:16] == 8'h00;
    endproperty
    property p_rpage;
        x_rd.en && x_rd.space == DAG_S_EXT
            |-> x_rd.addr[23:15] == $past(cfg.extended_read_page);
    endproperty
    property p_wpage;
        wr.en |-> wr.space != DAG_S_PROG && (wr.space != DAG_S_EXT
            || wr.addr[23:15] == $past(cfg.extended_write_page));
    endproperty
    property p_psv;
        x_rd.en && x_rd.space == DAG_S_PROG
            |-> $past(cfg.psv_en) && x_rd.addr[22:14] == $past(cfg.psv_page);
    endproperty
    property p_sp_rst;
        $fell(sys_rst) |-> stack_pointer_register == DAG_SP_RST;
    endproperty
    property p_inh;
        req.valid && !req.dual && req.src_mode == DAG_M_INHERENT
            && req.dst_mode == DAG_M_INHERENT
            |=> !x_rd.en && !wr.en && !reg_rd_valid;
    endproperty

    a_dual: assert property (p_dual) else $error("dual read missing");
    a_x_only: assert property (p_x_only) else $error("stray y read");
    a_rmw: assert property (p_rmw) else $error("read or write lost");
    a_stack: assert property (p_stack) else $error("stack paged");
    a_rpage: assert property (p_rpage) else $error("bad read page");
    a_wpage: assert property (p_wpage) else $error("bad write page");
    a_psv: assert property (p_psv) else $error("bad program window");
    a_sp_rst: assert property (p_sp_rst) else $error("bad sp reset");
    a_inh: assert property (p_inh) else $error("inherent access");
endmodule

bind dag_core dag_properties i_dag_properties (
    .mclk                  (mclk),
    .sys_rst               (sys_rst),
    .req                   (req),
    .cfg                   (cfg),
    .x_rd                  (x_rd),
    .y_rd                  (y_rd),
    .wr                    (wr),
    .reg_rd_valid          (reg_rd_valid),
    .stack_pointer_register(stack_pointer_register)
);
`default_nettype wire

// >>> tb/dag_mem_model.sv
// Memory side model counting the accesses it accepts
`timescale 1ns/1ps
`default_nettype none

module dag_mem_model (
    input  wire logic                 mclk,
    input  wire logic                 sys_rst,
    input  wire dag_pkg::dag_acc_type x_rd,
    input  wire dag_pkg::dag_acc_type y_rd,
    input  wire dag_pkg::dag_acc_type wr,
    output logic [15:0]               n_acc
);
    import dag_pkg::*;

    // Program space is read only; a write there is not counted
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            n_acc <= 16'h0000;
        end else begin
            n_acc <= n_acc + 16'(x_rd.en) + 16'(y_rd.en)
                + 16'(wr.en && wr.space != DAG_S_PROG);
        end
    end
endmodule
`default_nettype wire

// >>> tb/tb_top.sv
// Scenario bench for the data address generation block
`timescale 1ns/1ps
`default_nettype none

`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin err_total++; \
    $display("[FAIL] %s exp %h got %h", n, e, g); end end

module tb_top;
    import dag_pkg::*;

    // ****************************************
    // Signals and instances
    // ****************************************
    localparam dag_mode_type m_ind = DAG_M_REG_INDIRECT;
    localparam dag_mode_type m_inh = DAG_M_INHERENT;
    logic        mclk;
    logic        sys_rst;
    dag_req_type req;
    dag_cfg_type cfg;
    dag_wb_type  wb;
    dag_acc_type x_rd;
    dag_acc_type y_rd;
    dag_acc_type wr;
    logic [15:0] reg_rd_data;
    logic        reg_rd_valid;
    logic        space_fault;
    logic [15:0] sp;
    logic [15:0] n_acc;
    logic [15:0] exp_acc;
    dag_req_type r;
    int          err_total;
    int          checked;

    dag_core i_dag_core (.mclk(mclk), .sys_rst(sys_rst), .req(req),
        .cfg(cfg), .wb(wb), .x_rd(x_rd), .y_rd(y_rd), .wr(wr),
        .reg_rd_data(reg_rd_data), .reg_rd_valid(reg_rd_valid),
        .space_fault(space_fault), .stack_pointer_register(sp));
    dag_mem_model i_dag_mem_model (.mclk(mclk), .sys_rst(sys_rst),
        .x_rd(x_rd), .y_rd(y_rd), .wr(wr), .n_acc(n_acc));

    always #50 mclk = ~mclk;

    // ****************************************
    // Helpers
    // ****************************************
    function automatic dag_req_type mk(dag_mode_type sm, dag_imod_type sd,
                                       logic [3:0] sr, dag_mode_type dm,
                                       logic [3:0] dr);
        mk = '0;
        mk.valid = 1'b1;
        mk.src_mode = sm;
        mk.src_mod = sd;
        mk.src_reg = sr;
        mk.dst_mode = dm;
        mk.dst_reg = dr;
    endfunction

    function automatic dag_acc_type acc(dag_space_type s, logic [23:0] a);
        acc = {1'b1, s, a};
    endfunction

    // Idle edge first so no signal is driven twice in one step
    task automatic go(input dag_req_type q);
        @(posedge mclk);
        #1 req = q;
        @(posedge mclk);
        #1 req = '0;
    endtask

    task automatic wset(input logic [3:0] i, input logic [15:0] d);
        @(posedge mclk);
        #1 wb = {1'b1, i, d};
        @(posedge mclk);
        #1 wb = '0;
    endtask

    task automatic ca(input string n, input dag_acc_type e, g);
        `CHK(n, e, g)
        exp_acc = exp_acc + 16'(e.en);
    endtask

    task automatic rd(input logic [3:0] i, input logic [15:0] e);
        go(mk(DAG_M_REG_DIRECT, DAG_I_PLAIN, i, m_inh, 4'h0));
        `CHK("rvalid", 1'b1, reg_rd_valid)
        `CHK("reg", e, reg_rd_data)
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_walk;
        wset(4'h2, 16'h0100);
        wset(4'h3, 16'h8004);
        go(mk(m_ind, DAG_I_POST_INC, 4'h2, m_ind, 4'h3));
        ca("x", acc(DAG_S_BASE, 24'h000100), x_rd);
        ca("w", acc(DAG_S_EXT, {9'h005, 15'h0004}), wr);
        rd(4'h2, 16'h0102);
    endtask

    task automatic t_psv;
        cfg.psv_en = 1'b1;
        cfg.psv_page = 9'h003;
        go(mk(m_ind, DAG_I_PLAIN, 4'h3, m_inh, 4'h0));
        ca("psv", acc(DAG_S_PROG, {1'b0, 9'h003, 14'h0002}), x_rd);
        cfg.psv_en = 1'b0;
        go(mk(m_ind, DAG_I_PLAIN, 4'h3, m_inh, 4'h0));
        ca("eds", acc(DAG_S_EXT, {9'h003, 15'h0004}), x_rd);
    endtask

    task automatic t_stack;
        wset(4'hf, 16'h9001);
        `CHK("spr", 16'h9000, sp)
        go(mk(m_ind, DAG_I_PLAIN, 4'hf, m_inh, 4'h0));
        ca("sp", acc(DAG_S_BASE, 24'h009000), x_rd);
    endtask

    task automatic t_dual;
        cfg.ymod = {1'b1, 16'h9000, 16'h9003};
        wset(4'h8, 16'h1000);
        wset(4'ha, 16'h9002);
        r = '0;
        r.valid = 1'b1;
        r.dual = 1'b1;
        r.x_mod = DAG_I_POST_INC;
        r.y_mod = DAG_I_POST_INC;
        go(r);
        ca("dx", acc(DAG_S_BASE, 24'h001000), x_rd);
        ca("dy", acc(DAG_S_EXT, {9'h003, 15'h1002}), y_rd);
        `CHK("flt", 1'b0, space_fault)
        rd(4'h8, 16'h1002);
        rd(4'ha, 16'h9000);
        wset(4'h8, 16'h9000);
        go(r);
        `CHK("flt", 1'b1, space_fault)
        ca("fx", acc(DAG_S_EXT, {9'h003, 15'h1000}), x_rd);
        ca("fy", acc(DAG_S_EXT, {9'h003, 15'h1000}), y_rd);
        cfg.ymod = '0;
    endtask

    task automatic t_modx_brev;
        cfg.xmod = {1'b1, 16'h0100, 16'h0103};
        wset(4'h2, 16'h0102);
        go(mk(m_ind, DAG_I_POST_INC, 4'h2, m_inh, 4'h0));
        ca("mx", acc(DAG_S_BASE, 24'h000102), x_rd);
        rd(4'h2, 16'h0100);
        cfg.xmod = '0;
        cfg.brev = {1'b1, 16'h0008};
        wset(4'h2, 16'h0008);
        go(mk(m_ind, DAG_I_POST_INC, 4'h2, m_inh, 4'h0));
        ca("bx", acc(DAG_S_BASE, 24'h000008), x_rd);
        rd(4'h2, 16'h0004);
        cfg.brev = '0;
    endtask

    task automatic t_modes;
        dag_acc_type e;
        for (int m = 0; m < 6; m++) begin
            r = mk(dag_mode_type'(m), DAG_I_PLAIN, 4'h2, m_inh, 4'h0);
            r.direct = 16'h0200;
            e = '0;
            if (m == DAG_M_DIRECT) e = acc(DAG_S_BASE, 24'h000200);
            if (m == m_ind) e = acc(DAG_S_BASE, 24'h000004);
            go(r);
            ca("mode", e, x_rd);
            `CHK("mrv", m == DAG_M_REG_DIRECT, reg_rd_valid)
        end
    endtask

    // Remaining modifiers, byte step, alternate pointers, write priority
    task automatic t_mods;
        cfg.xmod = {1'b1, 16'h0100, 16'h0103};
        wset(4'h2, 16'h0100);
        go(mk(m_ind, DAG_I_PRE_DEC, 4'h2, m_inh, 4'h0));
        ca("pd", acc(DAG_S_BASE, 24'h000102), x_rd);
        r = mk(m_ind, DAG_I_POST_DEC, 4'h2, m_inh, 4'h0);
        r.byte_op = 1'b1;
        go(r);
        ca("bd", acc(DAG_S_BASE, 24'h000102), x_rd);
        cfg.xmod = '0;
        go(mk(m_ind, DAG_I_PRE_INC, 4'h2, m_inh, 4'h0));
        ca("pi", acc(DAG_S_BASE, 24'h000103), x_rd);
        wset(4'h4, 16'h0010);
        r = mk(m_ind, DAG_I_OFFSET, 4'h2, m_inh, 4'h0);
        r.offs_reg = 4'h4;
        go(r);
        ca("of", acc(DAG_S_BASE, 24'h000113), x_rd);
        rd(4'h2, 16'h0103);
        wset(4'h9, 16'h2000);
        wset(4'hb, 16'h8100);
        r = '0;
        r.valid = 1'b1;
        r.dual = 1'b1;
        r.x_sel = 1'b1;
        r.y_sel = 1'b1;
        r.x_mod = DAG_I_POST_INC;
        r.y_mod = DAG_I_POST_DEC;
        // Data write and pointer update hit the same register
        @(posedge mclk);
        #1 req = r;
        wb = {1'b1, 4'h9, 16'h0300};
        @(posedge mclk);
        #1 req = '0;
        wb = '0;
        ca("sx", acc(DAG_S_BASE, 24'h002000), x_rd);
        ca("sy", acc(DAG_S_EXT, {9'h003, 15'h0100}), y_rd);
        `CHK("sflt", 1'b0, space_fault)
        rd(4'h9, 16'h0300);
        rd(4'hb, 16'h80fe);
    endtask

    // ****************************************
    // Sequence and verdict
    // ****************************************
    task automatic conclude;
        $display("checks %0d errors %0d", checked, err_total);
        if (err_total == 0 && checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    initial begin
        mclk = 1'b0;
        sys_rst = 1'b1;
        req = '0;
        wb = '0;
        cfg = '0;
        cfg.extended_read_page = 9'h003;
        cfg.extended_write_page = 9'h005;
        exp_acc = 16'h0000;
        err_total = 0;
        checked = 0;
        repeat (20) @(posedge mclk);
        #1 sys_rst = 1'b0;
        t_walk();
        t_psv();
        t_stack();
        t_dual();
        t_modx_brev();
        t_modes();
        t_mods();
        @(posedge mclk);
        #1;
        `CHK("acc", exp_acc, n_acc)
        conclude();
    end

    // About 100 cycles are needed; cut off well beyond
    initial begin
        #200000;
        err_total++;
        conclude();
    end
endmodule
`default_nettype wire
